// ===== design/act_timebase.sv
`timescale 1ns/1ps
// ****************************************************************
// Functional notes
// - Sixteen-bit count seen as two byte registers
// - Low read snapshots high byte for next
// - Reads never disturb counting
// - Wrap from ffff sets overflow flag
// - Interrupt when flag set, mode enable set and mask set
// - Flag cleared only by software
// - Idle suspend zero keeps counting in idle
// - Three-bit select picks count tick source
// - Code 011 counts falling external edges
// - Code 101 counts external oscillator over eight
// - Run control gates counting
// ****************************************************************
module act_timebase (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic cpu_idle_i,
    input wire logic timer0_ovf_i,
    input wire logic timer4_ovf_i,
    input wire logic timer5_ovf_i,
    input wire logic external_count_input_i,
    input wire logic ext_osc_i,
    output logic irq_o
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // Three stages; a change counts once stages two and three agree.
    logic [2:0] eci_sync;
    logic [2:0] osc_sync;
    logic [2:0] next_eci_sync;
    logic [2:0] next_osc_sync;
    logic eci_level;
    logic osc_level;
    logic next_eci_level;
    logic next_osc_level;

    always_comb begin
        next_eci_sync = {eci_sync[1:0], external_count_input_i};
        next_osc_sync = {osc_sync[1:0], ext_osc_i};
        next_eci_level = (eci_sync[2] == eci_sync[1]) ? eci_sync[2] : eci_level;
        next_osc_level = (osc_sync[2] == osc_sync[1]) ? osc_sync[2] : osc_level;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            eci_sync <= 3'h7;
            osc_sync <= 3'h0;
            eci_level <= 1'b1;
            osc_level <= 1'b0;
        end else begin
            eci_sync <= next_eci_sync;
            osc_sync <= next_osc_sync;
            eci_level <= next_eci_level;
            osc_level <= next_osc_level;
        end
    end

    logic eci_fall;
    logic osc_rise;
    assign eci_fall = eci_level & ~next_eci_level;
    assign osc_rise = ~osc_level & next_osc_level;

    // ****************************************************************
    // Prescalers
    // ****************************************************************
    // The external oscillator must run well below half the system clock
    // for its edges to survive synchronisation.
    logic [3:0] div12;
    logic [1:0] div4;
    logic [2:0] div8;
    logic [3:0] next_div12;
    logic [1:0] next_div4;
    logic [2:0] next_div8;

    always_comb begin
        next_div12 = (div12 == 4'(act_pkg::DIV_SYS12 - 1)) ? 4'h0 : div12 + 4'h1;
        next_div4 = div4 + 2'h1;
        next_div8 = osc_rise ? div8 + 3'h1 : div8;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div12 <= 4'h0;
            div4 <= 2'h0;
            div8 <= 3'h0;
        end else begin
            div12 <= next_div12;
            div4 <= next_div4;
            div8 <= next_div8;
        end
    end

    logic ext8_tick;
    assign ext8_tick = osc_rise && (div8 == 3'(act_pkg::DIV_EXT8 - 1));

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] mode;
    logic run;
    logic ovf_flag;
    logic [15:0] count;
    logic [7:0] high_snap;
    logic irq_mask;
    logic [7:0] next_mode;
    logic next_run;
    logic next_ovf_flag;
    logic [15:0] next_count;
    logic [7:0] next_high_snap;
    logic next_irq_mask;
    logic [7:0] next_rdata;
    logic tick;
    act_pkg::act_timebase_t tb_sel;

    assign tb_sel = act_pkg::act_timebase_t'(mode[act_pkg::MODE_TIMEBASE_LSB +: 3]);

    always_comb begin
        unique case (tb_sel)
            act_pkg::ACT_TB_SYS12: tick = (div12 == 4'h0);
            act_pkg::ACT_TB_SYS4: tick = (div4 == 2'h0);
            act_pkg::ACT_TB_T0: tick = timer0_ovf_i;
            act_pkg::ACT_TB_ECI: tick = eci_fall;
            act_pkg::ACT_TB_SYS: tick = 1'b1;
            act_pkg::ACT_TB_EXT8: tick = ext8_tick;
            act_pkg::ACT_TB_T4: tick = timer4_ovf_i;
            act_pkg::ACT_TB_T5: tick = timer5_ovf_i;
        endcase
    end

    logic advance;
    logic wrap;
    // Idle only stops the count when suspend is requested.
    assign advance = run && tick
        && !(cpu_idle_i && mode[act_pkg::MODE_IDLE_SUSPEND_BIT]);
    assign wrap = advance && (count == act_pkg::COUNT_MAX);

    always_comb begin
        next_mode = mode;
        next_run = run;
        next_irq_mask = irq_mask;
        next_high_snap = high_snap;
        next_count = advance ? count + 16'h0001 : count;
        next_ovf_flag = ovf_flag;
        next_rdata = 8'h00;
        if (wr_i) begin
            unique case (addr_i)
                act_pkg::ADDR_COUNT_LOW: next_count = {count[15:8], wdata_i};
                act_pkg::ADDR_COUNT_HIGH: next_count = {wdata_i, count[7:0]};
                act_pkg::ADDR_MODE: next_mode = wdata_i;
                act_pkg::ADDR_CONTROL: begin
                    next_run = wdata_i[act_pkg::CTRL_RUN_BIT];
                    next_ovf_flag = wdata_i[act_pkg::CTRL_OVERFLOW_BIT];
                end
                act_pkg::ADDR_IRQ_STATUS: begin
                    if (wdata_i[0]) begin
                        next_ovf_flag = 1'b0;
                    end
                end
                act_pkg::ADDR_IRQ_MASK: next_irq_mask = wdata_i[0];
                default: next_mode = mode;
            endcase
        end
        // The hardware set wins over a software clear in the same cycle.
        if (wrap) begin
            next_ovf_flag = 1'b1;
        end
        if (rd_i) begin
            unique case (addr_i)
                act_pkg::ADDR_COUNT_LOW: begin
                    next_rdata = count[7:0];
                    next_high_snap = count[15:8];
                end
                act_pkg::ADDR_COUNT_HIGH: next_rdata = high_snap;
                act_pkg::ADDR_MODE: next_rdata = mode;
                act_pkg::ADDR_CONTROL: begin
                    next_rdata[act_pkg::CTRL_OVERFLOW_BIT] = ovf_flag;
                    next_rdata[act_pkg::CTRL_RUN_BIT] = run;
                end
                act_pkg::ADDR_IRQ_STATUS: next_rdata = {7'h00, ovf_flag};
                act_pkg::ADDR_IRQ_MASK: next_rdata = {7'h00, irq_mask};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode <= act_pkg::MODE_RESET;
            run <= 1'b0;
            ovf_flag <= 1'b0;
            count <= act_pkg::COUNT_RESET;
            high_snap <= 8'h00;
            irq_mask <= 1'b0;
            rdata_o <= 8'h00;
        end else begin
            mode <= next_mode;
            run <= next_run;
            ovf_flag <= next_ovf_flag;
            count <= next_count;
            high_snap <= next_high_snap;
            irq_mask <= next_irq_mask;
            rdata_o <= next_rdata;
        end
    end

    // The mode enable and the mask must both be set to raise the line.
    assign irq_o = ovf_flag && mode[act_pkg::MODE_IRQ_ENABLE_BIT] && irq_mask;

endmodule // act_timebase

// ===== include/act_pkg.sv
package act_pkg;
    // Register map, one word each on the plain register port.
    localparam logic [3:0] ADDR_COUNT_LOW = 4'h0;
    localparam logic [3:0] ADDR_COUNT_HIGH = 4'h1;
    localparam logic [3:0] ADDR_MODE = 4'h2;
    localparam logic [3:0] ADDR_CONTROL = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
    // Mode register fields.
    localparam int MODE_IDLE_SUSPEND_BIT = 7;
    localparam int MODE_TIMEBASE_LSB = 1;
    localparam int MODE_IRQ_ENABLE_BIT = 0;
    // Control register fields.
    localparam int CTRL_OVERFLOW_BIT = 7;
    localparam int CTRL_RUN_BIT = 6;
    // Reset values.
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    // Timebase dividers.
    localparam int DIV_SYS12 = 12;
    localparam int DIV_SYS4 = 4;
    localparam int DIV_EXT8 = 8;
    typedef enum logic [2:0] {
        ACT_TB_SYS12 = 3'b000,
        ACT_TB_SYS4 = 3'b001,
        ACT_TB_T0 = 3'b010,
        ACT_TB_ECI = 3'b011,
        ACT_TB_SYS = 3'b100,
        ACT_TB_EXT8 = 3'b101,
        ACT_TB_T4 = 3'b110,
        ACT_TB_T5 = 3'b111
    } act_timebase_t;
endpackage

// ===== sim/act_timebase_props.sv
`timescale 1ns/1ps
// ****************************************************************
// Checker on the block ports; interrupt output is combinational from registers.
// ****************************************************************
module act_timebase_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("stray read data");
    property p_unmap; rd_i && addr_i > 4'h5 |=> rdata_o == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_hold; irq_o && !wr_i |=> irq_o; endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_mask; wr_i && addr_i == 4'h5 && !wdata_i[0] |=> !irq_o; endproperty
    a_mask: assert property (p_mask) else $error("masked irq");
    property p_en; wr_i && addr_i == 4'h2 && !wdata_i[0] |=> !irq_o; endproperty
    a_en: assert property (p_en) else $error("disabled irq");
    property p_stat; irq_o && rd_i && addr_i == 4'h4 |=> rdata_o[0]; endproperty
    a_stat: assert property (p_stat) else $error("status bit");
    property p_ctrl; irq_o && rd_i && addr_i == 4'h3 |=> rdata_o[7]; endproperty
    a_ctrl: assert property (p_ctrl) else $error("flag bit");
    property p_mode; wr_i && addr_i == 4'h2 ##1 rd_i && addr_i == 4'h2
        |=> rdata_o == $past(wdata_i, 2); endproperty
    a_mode: assert property (p_mode) else $error("mode readback");
endmodule // act_timebase_props
bind act_timebase act_timebase_props u_props (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

// ===== sim/act_timebase_tb.sv
`timescale 1ns/1ps
module act_timebase_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, idle = 1'b0, rd_q = 1'b0;
    logic t0 = 1'b0, t4 = 1'b0, t5 = 1'b0, external_count_input = 1'b1, osc = 1'b0, irq_o;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o;
    logic [7:0] k[8];
    logic [15:0] q[$];
    int err_total = 0, cmp_count = 0;
    always #25 clk_i = ~clk_i;
    act_timebase uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cpu_idle_i(idle), .timer0_ovf_i(t0),
        .timer4_ovf_i(t4), .timer5_ovf_i(t5), .external_count_input_i(external_count_input), .ext_osc_i(osc),
        .irq_o(irq_o));
    task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
        wr_i <= w;
        rd_i <= r;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        q.push_back({m, e});
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic chk(input logic [7:0] got, input logic [15:0] e);
        if (e[15:8] != 8'h00) begin
            cmp_count++;
            if ((got & e[15:8]) !== e[7:0]) begin
                err_total++;
                $display("Error %0t read %h expected %h", $time, got, e[7:0]);
            end
        end
    endtask
    task automatic chk_irq(input logic e);
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        @(negedge clk_i);
        cmp_count++;
        if (irq_o !== e) begin
            err_total++;
            $display("Error %0t irq %b", $time, irq_o);
        end
        @(posedge clk_i);
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe, so sample at the falling edge.
    always @(posedge clk_i) rd_q <= rd_i;
    always @(negedge clk_i) if (rd_q) chk(rdata_o, q.pop_front());
    initial begin
        #200000;
        err_total++;
        final_report();
    end
    initial begin
        void'($urandom(32'hc251));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 2; a < 16; a++) rd(a[3:0], 8'h00, 8'hff);
        bus(1'b1, 1'b0, 4'h0, 8'h34);
        bus(1'b1, 1'b0, 4'h1, 8'h12);
        rd(4'h0, 8'h34, 8'hff);
        bus(1'b1, 1'b0, 4'h1, 8'h99);
        rd(4'h1, 8'h12, 8'hff);
        rd(4'h0, 8'h34, 8'hff);
        rd(4'h1, 8'h99, 8'hff);
        $display("test snapshot done");
        // Idle stays high so every window also proves counting goes on in idle.
        idle <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            foreach (k[j]) k[j] = 8'($urandom_range(1, 8));
            k[0] = 8'h08;
            k[1] = 8'h18;
            k[4] = 8'h60;
            k[5] = {7'h00, k[5][0]} + 8'h01;
            bus(1'b1, 1'b0, 4'h0, 8'h00);
            bus(1'b1, 1'b0, 4'h1, 8'h00);
            bus(1'b1, 1'b0, 4'h2, {4'h0, c[2:0], 1'b0});
            rd(4'h2, {4'h0, c[2:0], 1'b0}, 8'hff);
            bus(1'b1, 1'b0, 4'h3, 8'h40);
            for (int i = 0; i < 95; i++) begin
                t0 <= i < 2 * k[2] && i[0];
                t4 <= i < 2 * k[6] && !i[0];
                t5 <= i < 2 * k[7] && i[0];
                external_count_input <= !(i < 8 * k[3] && i[2]);
                osc <= i < 32 * k[5] && i[1];
                q.push_back(16'h0000);
                bus(1'b0, 1'b1, {3'h0, i[0]}, 8'h00);
            end
            bus(1'b1, 1'b0, 4'h3, 8'h00);
            rd(4'h0, k[c], 8'hff);
            rd(4'h1, 8'h00, 8'hff);
        end
        $display("test timebase done");
        bus(1'b1, 1'b0, 4'h0, 8'hfe);
        bus(1'b1, 1'b0, 4'h1, 8'hff);
        bus(1'b1, 1'b0, 4'h2, 8'h09);
        bus(1'b1, 1'b0, 4'h5, 8'h01);
        bus(1'b1, 1'b0, 4'h3, 8'h40);
        chk_irq(1'b0);
        repeat (2) bus(1'b0, 1'b0, 4'h0, 8'h00);
        chk_irq(1'b1);
        rd(4'h3, 8'hc0, 8'hc0);
        rd(4'h4, 8'h01, 8'h01);
        bus(1'b1, 1'b0, 4'h5, 8'h00);
        chk_irq(1'b0);
        bus(1'b1, 1'b0, 4'h5, 8'h01);
        chk_irq(1'b1);
        bus(1'b1, 1'b0, 4'h4, 8'h00);
        chk_irq(1'b1);
        bus(1'b1, 1'b0, 4'h4, 8'h01);
        chk_irq(1'b0);
        rd(4'h4, 8'h00, 8'h01);
        bus(1'b1, 1'b0, 4'h3, 8'h00);
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        $display("test overflow done");
        // Idle is still high, so with suspend set the count must hold.
        bus(1'b1, 1'b0, 4'h0, 8'h00);
        bus(1'b1, 1'b0, 4'h1, 8'h00);
        bus(1'b1, 1'b0, 4'h2, 8'h88);
        bus(1'b1, 1'b0, 4'h3, 8'h40);
        repeat (4) bus(1'b0, 1'b0, 4'h0, 8'h00);
        bus(1'b1, 1'b0, 4'h3, 8'h00);
        rd(4'h0, 8'h00, 8'hff);
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        $display("test idle suspend done");
        final_report();
    end
endmodule // act_timebase_tb
